/* hdl/wwan_sideband_pkg.sv */
// constants and types for the sideband pin multiplexer
// assumes a single 100 MHz system clock
package wwan_sideband_pkg;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_FREQ_HZ       = 100_000_000;
   localparam int CLK_PERIOD_NS     = 10;
   localparam int WAKE_PULSE_MS     = 1000;
   localparam int WAKE_PULSE_CYCLES = WAKE_PULSE_MS * (CLK_FREQ_HZ / 1000);
   localparam int SYNC_CLK_HZ       = 1_000_000;
   localparam int SYNC_HALF_CYCLES  = CLK_FREQ_HZ / (2 * SYNC_CLK_HZ);

   // ****************************************************************
   // structure
   // ****************************************************************
   localparam int PIN_COUNT   = 12;
   localparam int CARD_COUNT  = 2;
   localparam int SYNC_WIDTH  = PIN_COUNT + 1;
   localparam int PIN_CARD2_DETECT = 0;
   localparam int PIN_LOC_CLOCK    = 0;
   localparam int PIN_TX_BLANK     = 4;
   localparam int PIN_STATUS       = 9;
   localparam int PIN_HOST_WAKE    = 11;
   localparam logic [1:0]  CFG_RESET = 2'h0;
   localparam logic [11:0] PINS_IDLE = 12'h000;

   typedef enum logic [1:0] {
      CFG_LOCATION_A,
      CFG_LOCATION_B,
      CFG_SECOND_CARD,
      CFG_INTERPROC
   } port_cfg_type;

   typedef enum logic {
      WAKE_IDLE,
      WAKE_PULSE
   } wake_state_type;

endpackage

/* hdl/wwan_pin_sync.sv */
// three-stage synchroniser with agreement filter
// assumes asynchronous inputs; output level is registered
`timescale 1ns/10ps
module wwan_pin_sync
#(
   parameter int WIDTH = 13
)
(
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_level
);

   logic [WIDTH-1:0] ff1_r;
   logic [WIDTH-1:0] ff2_r;
   logic [WIDTH-1:0] ff3_r;
   logic [WIDTH-1:0] agree;
   logic [WIDTH-1:0] level_nxt;

   if (WIDTH < 1)
   begin : g_bad_width
      $error("wwan_pin_sync: WIDTH must be at least 1");
   end

   // a change counts once stages two and three agree
   assign agree     = ~(ff2_r ^ ff3_r);
   assign level_nxt = (ff3_r & agree) | (o_level & ~agree);

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ff1_r   <= '0;
         ff2_r   <= '0;
         ff3_r   <= '0;
         o_level <= '0;
      end
      else
      begin
         ff1_r   <= i_async;
         ff2_r   <= ff1_r;
         ff3_r   <= ff2_r;
         o_level <= level_nxt;
      end
   end

endmodule

/* hdl/wwan_sideband_pin_mux.sv */
// sideband pin multiplexer, card detect, wake and blanking outputs
// assumes pads resolve pin level from out/oe; straps stable at reset
//
// Functional notes
// - twelve pins follow exactly one of four latched port configurations
// - config 0: location i2c, sync clock, blanking, audio, lamp, wake
// - config 1: as config 0, pins 3-4 carry vendor location lines
// - config 2: second card on pins 0-4, pins 5-8 reserved idle
// - config 3: interprocessor, audio, drive activity, hsic lines
// - pin 9 may carry interprocessor line 7 instead of lamp
// - config 3 pin 9 may carry line 7 instead of drive activity
// - detect rising means insertion, falling removal, low means absent
// - detect edges or level raise an interrupt
// - power-on input high enables, low shuts whole block down
// - power-off input acts asynchronously, independent of clock
// - active-low modem reset holds block in reset at once
// - modem reset clears all held state
// - blanking output (pin 4, config 0 only) high while radio transmits
// - block generates sync clock itself from divider
// - location i2c clock pin is input only
// - location interrupt pin is bidirectional
// - second card data driven when card receives, input otherwise
// - up to two card interfaces with own detect
// - host wake driven low as a single one-second pulse in configs 0-2; pin 11 carries hsic in config 3
`timescale 1ns/10ps
module wwan_sideband_pin_mux
   import wwan_sideband_pkg::*;
#(
   parameter int WAKE_CYCLES = WAKE_PULSE_CYCLES,
   parameter int SYNC_HALF   = SYNC_HALF_CYCLES
)
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_n,
   input  wire logic        i_full_power_on,
   input  wire logic        i_modem_reset_n,
   input  wire logic [1:0]  i_port_config,
   input  wire logic        i_pin9_ipc_sel,
   input  wire logic        i_cfg3_ipc_sel,
   input  wire logic [11:0] i_gpio_in,
   output logic      [11:0] o_gpio_out,
   output logic      [11:0] o_gpio_oe,
   output logic      [11:0] o_pin_level,
   input  wire logic        i_location_i2c_data_low,
   input  wire logic        i_location_interrupt_low,
   input  wire logic [1:0]  i_vendor_location_out,
   input  wire logic [1:0]  i_vendor_location_oe,
   input  wire logic [3:0]  i_audio_out,
   input  wire logic [3:0]  i_audio_oe,
   input  wire logic [7:0]  i_interprocessor_out,
   input  wire logic [7:0]  i_interprocessor_oe,
   input  wire logic        i_drive_activity_spinup,
   input  wire logic [1:0]  i_hsic_out,
   input  wire logic [1:0]  i_hsic_oe,
   input  wire logic        i_status_lamp_on,
   input  wire logic        i_radio_tx_active,
   input  wire logic        i_second_card_io_out,
   input  wire logic        i_second_card_io_oe,
   input  wire logic        i_second_card_clock,
   input  wire logic        i_second_card_reset,
   input  wire logic        i_second_card_power,
   input  wire logic        i_card_present_in,
   input  wire logic        i_card_irq_level_mode,
   input  wire logic        i_card_irq_clear,
   input  wire logic        i_wake_request,
   output logic [1:0]       o_card_present,
   output logic [1:0]       o_card_inserted,
   output logic [1:0]       o_card_removed,
   output logic             o_card_irq,
   output logic             o_host_wake_busy,
   output logic [1:0]       o_port_config,
   output logic             o_module_enabled
);

   localparam int WCW = $clog2(WAKE_CYCLES + 1);
   localparam int SCW = $clog2(SYNC_HALF + 1);
   localparam logic [WCW-1:0] WAKE_LAST = WCW'(WAKE_CYCLES - 1);
   localparam logic [SCW-1:0] SYNC_LAST = SCW'(SYNC_HALF - 1);

   if (WAKE_CYCLES < 2 || SYNC_HALF < 1)
   begin : g_bad_param
      $error("wwan_sideband_pin_mux: timing parameters too small");
   end

   // ****************************************************************
   // whole-block reset
   // ****************************************************************
   logic core_rst_n;

   // power-off, modem reset and system reset all act without clock
   assign core_rst_n = i_rst_n & i_full_power_on & i_modem_reset_n;

   // ****************************************************************
   // configuration latch
   // ****************************************************************
   port_cfg_type cfg_r;
   logic         latched_r;
   logic         pin9_ipc_r;
   logic         cfg3_ipc_r;

   // straps caught on first edge after release, then frozen
   always_ff @(posedge i_clk_sys or negedge core_rst_n)
   begin
      if (!core_rst_n)
      begin
         cfg_r      <= port_cfg_type'(CFG_RESET);
         latched_r  <= 1'b0;
         pin9_ipc_r <= 1'b0;
         cfg3_ipc_r <= 1'b0;
      end
      else if (!latched_r)
      begin
         cfg_r      <= port_cfg_type'(i_port_config);
         latched_r  <= 1'b1;
         pin9_ipc_r <= i_pin9_ipc_sel;
         cfg3_ipc_r <= i_cfg3_ipc_sel;
      end
   end

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   logic [SYNC_WIDTH-1:0] sync_level;

   wwan_pin_sync #(
      .WIDTH (SYNC_WIDTH)
   ) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (core_rst_n),
      .i_async   ({i_card_present_in, i_gpio_in}),
      .o_level   (sync_level)
   );

   assign o_pin_level = sync_level[PIN_COUNT-1:0];

   // ****************************************************************
   // card detect, two channels
   // ****************************************************************
   logic [1:0] detect_level;
   logic [1:0] card_event;
   logic       irq_nxt;

   assign detect_level[0] = sync_level[PIN_COUNT];
   // second detect only exists while pin 0 carries it
   assign detect_level[1] = (cfg_r == CFG_SECOND_CARD) && latched_r &&
                            sync_level[PIN_CARD2_DETECT];

   for (genvar c = 0; c < CARD_COUNT; c++)
   begin : g_card
      always_ff @(posedge i_clk_sys or negedge core_rst_n)
      begin
         if (!core_rst_n)
         begin
            o_card_present[c]  <= 1'b0;
            o_card_inserted[c] <= 1'b0;
            o_card_removed[c]  <= 1'b0;
         end
         else
         begin
            o_card_present[c]  <= detect_level[c];
            o_card_inserted[c] <= detect_level[c] & ~o_card_present[c];
            o_card_removed[c]  <= ~detect_level[c] & o_card_present[c];
         end
      end
      assign card_event[c] = detect_level[c] ^ o_card_present[c];
   end

   // edge mode is sticky and set wins over clear; level mode follows
   assign irq_nxt = i_card_irq_level_mode ? |detect_level :
                    (o_card_irq & ~i_card_irq_clear) | |card_event;

   always_ff @(posedge i_clk_sys or negedge core_rst_n)
   begin
      if (!core_rst_n)
         o_card_irq <= 1'b0;
      else
         o_card_irq <= irq_nxt;
   end

   // ****************************************************************
   // sync clock divider
   // ****************************************************************
   logic [SCW-1:0] sync_cnt_r;
   logic           sync_en;
   logic           sync_clk_r;

   assign sync_en = (sync_cnt_r == SYNC_LAST);

   always_ff @(posedge i_clk_sys or negedge core_rst_n)
   begin
      if (!core_rst_n)
      begin
         sync_cnt_r <= '0;
         sync_clk_r <= 1'b0;
      end
      else
      begin
         sync_cnt_r <= sync_en ? '0 : sync_cnt_r + 1'b1;
         if (sync_en)
            sync_clk_r <= ~sync_clk_r;
      end
   end

   // ****************************************************************
   // host wake pulse
   // ****************************************************************
   wake_state_type wake_state_r;
   wake_state_type wake_state_nxt;
   logic [WCW-1:0] wake_cnt_r;
   logic           wake_active;

   always_comb
   begin
      wake_state_nxt = wake_state_r;
      case (wake_state_r)
         WAKE_IDLE:
            if (i_wake_request)
               wake_state_nxt = WAKE_PULSE;
         WAKE_PULSE:
            if (wake_cnt_r == WAKE_LAST)
               wake_state_nxt = WAKE_IDLE;
         default:
            wake_state_nxt = WAKE_IDLE;
      endcase
   end

   assign wake_active = (wake_state_r == WAKE_PULSE);

   always_ff @(posedge i_clk_sys or negedge core_rst_n)
   begin
      if (!core_rst_n)
      begin
         wake_state_r <= WAKE_IDLE;
         wake_cnt_r   <= '0;
      end
      else
      begin
         wake_state_r <= wake_state_nxt;
         wake_cnt_r   <= wake_active ? wake_cnt_r + 1'b1 : '0;
      end
   end

   // ****************************************************************
   // pin mapping per configuration
   // ****************************************************************
   logic        pin9_out;
   logic        pin9_oe;
   logic [1:0]  pin78_out;
   logic [1:0]  pin78_oe;
   logic [11:0] out_loc_a;
   logic [11:0] oe_loc_a;
   logic [11:0] out_loc_b;
   logic [11:0] oe_loc_b;
   logic [11:0] out_card;
   logic [11:0] oe_card;
   logic [11:0] out_ipc;
   logic [11:0] oe_ipc;
   logic [11:0] out_sel;
   logic [11:0] oe_sel;

   assign pin9_out = pin9_ipc_r ? i_interprocessor_out[7] :
                     (cfg_r == CFG_INTERPROC) ? i_drive_activity_spinup :
                     ~i_status_lamp_on;
   assign pin9_oe  = pin9_ipc_r ? i_interprocessor_oe[7] : 1'b1;
   assign pin78_out = cfg3_ipc_r ? i_interprocessor_out[6:5] :
                      i_audio_out[3:2];
   assign pin78_oe  = cfg3_ipc_r ? i_interprocessor_oe[6:5] :
                      i_audio_oe[3:2];

   // i2c clock and radio-off are inputs; data, irq and wake pull low
   assign out_loc_a = {2'b00, pin9_out, i_audio_out,
                       i_radio_tx_active, sync_clk_r, 3'b000};
   assign oe_loc_a  = {wake_active, 1'b0, pin9_oe, i_audio_oe, 2'b11,
                       i_location_interrupt_low,
                       i_location_i2c_data_low, 1'b0};
   assign out_loc_b = {out_loc_a[11:5], i_vendor_location_out,
                       out_loc_a[2:0]};
   assign oe_loc_b  = {oe_loc_a[11:5], i_vendor_location_oe,
                       oe_loc_a[2:0]};
   // reserved pins 5-8 stay undriven
   assign out_card  = {2'b00, pin9_out, 4'h0, i_second_card_power,
                       i_second_card_reset, i_second_card_clock,
                       i_second_card_io_out, 1'b0};
   assign oe_card   = {wake_active, 1'b0, pin9_oe, 4'h0, 3'b111,
                       i_second_card_io_oe, 1'b0};
   assign out_ipc   = {i_hsic_out, pin9_out, pin78_out,
                       i_audio_out[1:0], i_interprocessor_out[4:0]};
   assign oe_ipc    = {i_hsic_oe, pin9_oe, pin78_oe,
                       i_audio_oe[1:0], i_interprocessor_oe[4:0]};

   assign out_sel = (cfg_r == CFG_LOCATION_A)  ? out_loc_a :
                    (cfg_r == CFG_LOCATION_B)  ? out_loc_b :
                    (cfg_r == CFG_SECOND_CARD) ? out_card  : out_ipc;
   assign oe_sel  = !latched_r                 ? PINS_IDLE :
                    (cfg_r == CFG_LOCATION_A)  ? oe_loc_a  :
                    (cfg_r == CFG_LOCATION_B)  ? oe_loc_b  :
                    (cfg_r == CFG_SECOND_CARD) ? oe_card   : oe_ipc;

   always_ff @(posedge i_clk_sys or negedge core_rst_n)
   begin
      if (!core_rst_n)
      begin
         o_gpio_out       <= PINS_IDLE;
         o_gpio_oe        <= PINS_IDLE;
         o_host_wake_busy <= 1'b0;
         o_port_config    <= CFG_RESET;
         o_module_enabled <= 1'b0;
      end
      else
      begin
         o_gpio_out       <= out_sel;
         o_gpio_oe        <= oe_sel;
         o_host_wake_busy <= wake_active;
         o_port_config    <= cfg_r;
         o_module_enabled <= latched_r;
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!core_rst_n);

   cfg_static_a: assert property (latched_r |=> $stable(cfg_r))
      else $error("port configuration changed after latch");
   clock_input_a: assert property (
      latched_r && cfg_r inside {CFG_LOCATION_A, CFG_LOCATION_B}
      |=> !o_gpio_oe[PIN_LOC_CLOCK])
      else $error("location clock pin driven");
   insert_pulse_a: assert property (
      $rose(detect_level[0]) |=> o_card_inserted[0] ##1 !o_card_inserted[0])
      else $error("insertion pulse missing or long");
   irq_set_a: assert property (
      !i_card_irq_level_mode && |card_event |=> o_card_irq)
      else $error("card event did not raise interrupt");
   blank_follow_a: assert property (
      latched_r && cfg_r == CFG_LOCATION_A
      |=> o_gpio_out[PIN_TX_BLANK] == $past(i_radio_tx_active)
          && o_gpio_oe[PIN_TX_BLANK])
      else $error("blanking does not follow transmit");
   wake_hold_a: assert property (
      wake_active && wake_cnt_r != WAKE_LAST |=> wake_active)
      else $error("wake pulse ended early");
   wake_end_a: assert property (
      wake_active && wake_cnt_r == WAKE_LAST |=> !wake_active ##1
      !o_gpio_oe[PIN_HOST_WAKE] || cfg_r == CFG_INTERPROC)
      else $error("wake pulse too long");
   reserved_idle_a: assert property (
      latched_r && cfg_r == CFG_SECOND_CARD |=> o_gpio_oe[8:5] == 4'h0)
      else $error("reserved pins driven");
   sync_toggle_a: assert property (sync_en |=> $changed(sync_clk_r))
      else $error("sync clock did not toggle");
   card_io_dir_a: assert property (
      latched_r && cfg_r == CFG_SECOND_CARD
      |=> o_gpio_oe[1] == $past(i_second_card_io_oe))
      else $error("card data direction wrong");
   pin9_ipc_a: assert property (
      latched_r && pin9_ipc_r
      |=> o_gpio_out[PIN_STATUS] == $past(i_interprocessor_out[7]))
      else $error("pin 9 not carrying line 7");
   power_off_a: assert property (disable iff (1'b0)
      !i_full_power_on |-> !o_module_enabled && o_gpio_oe == PINS_IDLE)
      else $error("block active while powered off");

   wake_cover_c: cover property ($fell(wake_active));
   insert_cover_c: cover property (o_card_inserted[0]);
   card2_cover_c: cover property (o_card_removed[1]);
   ipc_cover_c: cover property (latched_r && cfg_r == CFG_INTERPROC);

endmodule

/* tb/wwan_far_side_model.sv */
// far side of the pins: host platform and location sensor hub
// assumes the bench picks which lines the far side drives
`timescale 1ns/10ps
module wwan_far_side_model
(
   input  wire logic        i_clk_sys,
   input  wire logic [11:0] i_dev_out,
   input  wire logic [11:0] i_dev_oe,
   input  wire logic [11:0] i_ext_oe,
   input  wire logic [11:0] i_ext_val,
   output logic      [11:0] o_pad
);
   // ****************************************************************
   // pad resolution
   // ****************************************************************
   // open-drain lamp, interrupt, data and wake lines carry pull-ups
   localparam logic [11:0] PULLED_UP = 12'hA06;
   logic [11:0] float_r = 12'hA5A;
   logic [11:0] idle_lvl;
   always_ff @(posedge i_clk_sys)
   begin
      float_r <= ~float_r;
   end
   // undriven lines without pull show a changing pattern
   assign idle_lvl = PULLED_UP | (float_r & ~PULLED_UP);
   // hub masters i2c clock and may pull the interrupt line
   assign o_pad = (i_dev_oe & i_dev_out)
                | (~i_dev_oe & i_ext_oe & i_ext_val)
                | (~i_dev_oe & ~i_ext_oe & idle_lvl);
endmodule

/* tb/tb.sv */
// self-checking bench of the sideband pin multiplexer
// assumes the far side model resolves the pads
`timescale 1ns/10ps
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module tb;
   import wwan_sideband_pkg::*;
   localparam int WAKE = 20;
   localparam int HALF = 2;
   logic        clk_sys = 0, rst_n = 0, pwr_on = 1, modem_rst_n = 1;
   logic [1:0]  cfg = 0;
   logic        s9 = 0, s3 = 0, card_in = 0, lvl_mode = 0;
   logic        irq_clr = 0, wake_req = 0;
   logic [41:0] stim = '0;
   logic [11:0] ext_oe = '0, ext_val = '0, pad;
   logic [11:0] gpio_out, gpio_oe, pin_level;
   logic [1:0]  present, inserted, removed, port_cfg;
   logic        card_irq, wake_busy, enabled;
   logic [23:0] ex;
   int          err_total = 0, checks = 0, n;
   always #5 clk_sys = ~clk_sys;
   wwan_far_side_model far_u (.i_clk_sys(clk_sys), .i_dev_out(gpio_out),
      .i_dev_oe(gpio_oe), .i_ext_oe(ext_oe), .i_ext_val(ext_val),
      .o_pad(pad));
   wwan_sideband_pin_mux #(.WAKE_CYCLES(WAKE), .SYNC_HALF(HALF)) dut_u (
      .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_full_power_on(pwr_on),
      .i_modem_reset_n(modem_rst_n), .i_port_config(cfg),
      .i_pin9_ipc_sel(s9), .i_cfg3_ipc_sel(s3), .i_gpio_in(pad),
      .o_gpio_out(gpio_out), .o_gpio_oe(gpio_oe), .o_pin_level(pin_level),
      .i_location_i2c_data_low(stim[0]), .i_location_interrupt_low(stim[1]),
      .i_vendor_location_out(stim[3:2]), .i_vendor_location_oe(stim[5:4]),
      .i_audio_out(stim[9:6]), .i_audio_oe(stim[13:10]),
      .i_interprocessor_out(stim[21:14]), .i_interprocessor_oe(stim[29:22]),
      .i_drive_activity_spinup(stim[30]), .i_hsic_out(stim[32:31]),
      .i_hsic_oe(stim[34:33]), .i_status_lamp_on(stim[35]),
      .i_radio_tx_active(stim[36]), .i_second_card_io_out(stim[37]),
      .i_second_card_io_oe(stim[38]), .i_second_card_clock(stim[39]),
      .i_second_card_reset(stim[40]), .i_second_card_power(stim[41]),
      .i_card_present_in(card_in), .i_card_irq_level_mode(lvl_mode),
      .i_card_irq_clear(irq_clr), .i_wake_request(wake_req),
      .o_card_present(present), .o_card_inserted(inserted),
      .o_card_removed(removed), .o_card_irq(card_irq),
      .o_host_wake_busy(wake_busy), .o_port_config(port_cfg),
      .o_module_enabled(enabled));
   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic check(string name, logic [31:0] e, logic [31:0] g);
      checks++;
      if (e !== g)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask
   task automatic do_reset(logic [1:0] c);
      @(negedge clk_sys);
      rst_n = 0;
      cfg = c;
      repeat (16) @(negedge clk_sys);
      rst_n = 1;
      repeat (3) tick();
   endtask
   // expected {oe, out} of the twelve pins
   function automatic logic [23:0] exp_map(logic [1:0] c, logic p9,
                                           logic p3, logic [41:0] s);
      logic [11:0] o, e;
      o = '0;
      e = '0;
      if (c != 2'h3)
      begin
         e[2:1] = s[1:0];
         e[9] = 1'b1;
         o[9] = ~s[35];
         if (c != 2'h2)
         begin
            o[8:5] = s[9:6];
            e[8:5] = s[13:10];
         end
         if (c == 2'h0)
         begin
            o[4] = s[36];
            e[4:3] = 2'h3;
         end
         if (c == 2'h1)
         begin
            o[4:3] = s[3:2];
            e[4:3] = s[5:4];
         end
         if (c == 2'h2)
         begin
            o[4:1] = {s[41:39], s[37]};
            e[4:1] = {3'h7, s[38]};
         end
      end
      else
      begin
         o[6:0] = {s[7:6], s[18:14]};
         e[6:0] = {s[11:10], s[26:22]};
         o[8:7] = p3 ? s[20:19] : s[9:8];
         e[8:7] = p3 ? s[28:27] : s[13:12];
         o[11:9] = {s[32:31], s[30]};
         e[11:9] = {s[34:33], 1'b1};
      end
      if (p9)
      begin
         o[9] = s[21];
         e[9] = s[29];
      end
      return {e, o};
   endfunction
   // host decode of the four configuration straps into a port config
   function automatic logic [1:0] host_cfg(logic [3:0] st);
      if (st inside {4'h2, 4'h3, 4'hC, 4'hD})
         return {st[3], st[0]};
      return st[1:0];
   endfunction
   // ****************************************************************
   // tests
   // ****************************************************************
   logic [11:0] m;
   initial
   begin
      void'($urandom(87642));
      for (int c = 0; c < 4; c++)
      begin
         s9 = 1'($urandom);
         s3 = 1'($urandom);
         do_reset(host_cfg(4'(($urandom % 2) * 4 + 4 + c)));
         `CHK("enabled", 1, enabled);
         for (int i = 0; i < 12; i++)
         begin
            @(negedge clk_sys);
            stim = 42'({$urandom, $urandom});
            cfg = 2'($urandom);
            ext_oe = 12'h001;
            ext_val = 12'(i & 1);
            tick();
            ex = exp_map(2'(c), s9, s3, stim);
            m = ex[23:12] & ((c == 0) ? 12'hFF7 : 12'hFFF);
            `CHK("oe", ex[23:12], gpio_oe);
            `CHK("out", ex[11:0] & m, gpio_out & m);
            `CHK("cfg", c, port_cfg);
            repeat (5) tick();
            m = m | 12'h001;
            `CHK("level", pad & m, pin_level & m);
         end
         $display("test map config %0d done", c);
      end
      // second card detect on pin 0 in config 2
      do_reset(host_cfg(4'hC));
      @(negedge clk_sys);
      ext_val = 12'h001;
      repeat (8) tick();
      `CHK("card2", 2'h2, present);
      $display("test second card done");
      // sync clock and card events in config 0
      do_reset(host_cfg(4'h2));
      n = 0;
      for (int i = 0; i < 16; i++)
      begin
         m[0] = gpio_out[3];
         tick();
         n += (gpio_out[3] !== m[0]);
      end
      `CHK("sync", 16 / HALF, n);
      @(negedge clk_sys);
      card_in = 1;
      for (n = 0; n < 12 && inserted[0] !== 1'b1; n++) tick();
      `CHK("ins1", 2'h1, inserted);
      `CHK("present", 2'h1, present);
      `CHK("irq", 1, card_irq);
      tick();
      `CHK("ins", 2'h0, inserted);
      @(negedge clk_sys);
      irq_clr = 1;
      @(negedge clk_sys);
      irq_clr = 0;
      card_in = 0;
      #2;
      `CHK("clr", 0, card_irq);
      for (n = 0; n < 12 && removed[0] !== 1'b1; n++) tick();
      `CHK("rem", 2'h1, removed);
      `CHK("gone", 2'h0, present);
      `CHK("irq2", 1, card_irq);
      @(negedge clk_sys);
      lvl_mode = 1;
      repeat (2) tick();
      `CHK("lvl", 0, card_irq);
      $display("test card detect done");
      // wake pulse, retriggers ignored while busy
      @(negedge clk_sys);
      wake_req = 1;
      for (n = 0; n < 5 && wake_busy !== 1'b1; n++) tick();
      `CHK("wake", 2'h2, {gpio_oe[11], gpio_out[11]});
      n = 0;
      while (wake_busy === 1'b1 && n < 100)
      begin
         n++;
         if (n == 3)
         begin
            @(negedge clk_sys);
            wake_req = 0;
         end
         tick();
      end
      `CHK("wakelen", WAKE, n);
      `CHK("wakeoff", 0, gpio_oe[11]);
      $display("test wake done");
      // asynchronous power off and modem reset
      @(negedge clk_sys);
      card_in = 1;
      cfg = 2'h3;
      repeat (8) tick();
      @(negedge clk_sys);
      pwr_on = 0;
      #1;
      `CHK("pwroff", 0, {gpio_oe, enabled});
      repeat (2) @(negedge clk_sys);
      pwr_on = 1;
      repeat (4) tick();
      `CHK("pwron", 3'h7, {port_cfg, enabled});
      repeat (8) tick();
      `CHK("pres", 2'h1, present);
      @(negedge clk_sys);
      modem_rst_n = 0; // host resets only on failure
      #1;
      `CHK("mreset", 0, {present, card_irq, gpio_oe});
      @(negedge clk_sys);
      modem_rst_n = 1;
      $display("test power and reset done");
      test_done();
   end
   initial
   begin
      #200_000;
      err_total++;
      $display("Error watchdog expected done seen hang");
      test_done();
   end
endmodule
